// ---- hw/rts_map.svh ----
// Register offsets, field positions, reset values and timing counts of the reset sequencer
`ifndef RTS_MAP_SVH
`define RTS_MAP_SVH
// ============================================================
// Register map
`define RTS_POWER_CONTROL_FLAGS_ADDR       12'h238
`define RTS_POWER_CONTROL_FLAGS_IDX        8'h8e
`define RTS_CTRL_ADDR       12'h000
`define RTS_STAT_ADDR       12'h004
`define RTS_POWER_CONTROL_FLAGS_POR_BIT    1
`define RTS_POWER_CONTROL_FLAGS_MASK       8'h02
// ============================================================
// Reset values and interrupt vector
`define RTS_STATUS_HI_POR   3'h0
`define RTS_PC_RESET        13'h0000
`define RTS_PC_IRQ_VEC      13'h0004
// ============================================================
// Timing
`define RTS_POWER_UP_TIMER_MS         72
`define RTS_SLOW_KHZ        32
`define RTS_POWER_UP_TIMER_CYC        (`RTS_POWER_UP_TIMER_MS * `RTS_SLOW_KHZ)
`define RTS_OST_CYC         1024
`define RTS_MASTER_CLEAR_N_FILT_NS    20
`define RTS_CLK_NS          4
`define RTS_MASTER_CLEAR_N_FILT_CYC   ((`RTS_MASTER_CLEAR_N_FILT_NS + `RTS_CLK_NS - 1) / `RTS_CLK_NS)
`endif

// ---- hw/rts_pkg.sv ----
// Types of the reset sequencer
package rts_pkg;
  typedef enum logic [2:0]
  {
    RTS_XT   = 3'h0,
    RTS_HS   = 3'h1,
    RTS_LP   = 3'h2,
    RTS_INRC = 3'h4,
    RTS_EXRC = 3'h6
  } rts_osc_mode_t;

  typedef enum logic [2:0]
  {
    RTS_ST_POR  = 3'h0,
    RTS_ST_POWER_UP_TIMER = 3'h1,
    RTS_ST_OST  = 3'h2,
    RTS_ST_HOLD = 3'h3,
    RTS_ST_RUN  = 3'h4,
    RTS_ST_SLP  = 3'h5
  } rts_state_t;
endpackage

// ---- hw/rts_reset_seq.sv ----
// Reset and start-up sequencer with power control register on APB
`timescale 1ns/10ps
`include "rts_map.svh"
module rts_reset_seq #(
  parameter int POWER_UP_TIMER_CYCLES = `RTS_POWER_UP_TIMER_CYC,
  parameter int OST_CYCLES  = `RTS_OST_CYC
)(
  input  wire logic                  clk_i,
  input  wire logic                  resetn_i,
  input  wire logic                  por_supply_ok_i,
  input  wire logic                  slow_tick_i,
  input  wire logic                  osc_input_pin_i,
  input  wire logic [2:0]            osc_mode_i,
  input  wire logic                  clkout_en_i,
  input  wire logic                  power_up_timer_enable_n_i,
  input  wire logic                  master_clear_n_i,
  input  wire logic                  wdt_timeout_i,
  input  wire logic                  sleep_req_i,
  input  wire logic                  irq_wake_i,
  input  wire logic                  global_irq_enable_i,
  input  wire logic [12:0]           pc_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [11:0]           paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic                       pready_o,
  output logic                       pslverr_o,
  output logic [31:0]                prdata_o,
  output logic                       chip_reset_o,
  output logic                       pc_load_o,
  output logic [12:0]                pc_value_o,
  output logic                       watchdog_timeout_flag_o,
  output logic                       power_down_flag_o,
  output logic                       osc_output_pin_o,
  output logic                       osc_output_pin_oe_n_o,
  output logic                       osc_input_pin_oe_n_o
);
  // ============================================================
  // State
  typedef struct packed {
    rts_pkg::rts_state_t st;
    logic [31:0]         cnt;
    logic [7:0]          filt;
    logic                master_clear_n_n;
    logic                osc_d;
    logic                por_flag;
    logic                to_flag;
    logic                pd_flag;
    logic                was_sleep;
    logic                wake_master_clear_n;
    logic                pc_load;
    logic [12:0]         pc_val;
    logic                reset;
    logic                ready;
    logic                slverr;
    logic [31:0]         rdata;
    logic                oe2_n;
    logic                oe1_n;
  } rts_reg_t;

  rts_reg_t r;
  rts_reg_t next_r;

  logic crystal;
  logic rc_mode;
  logic osc_rise;
  logic access;
  logic hit_power_control_flags;
  logic hit_stat;

  always_comb
  begin
    crystal  = (osc_mode_i == rts_pkg::RTS_XT) || (osc_mode_i == rts_pkg::RTS_HS) ||
               (osc_mode_i == rts_pkg::RTS_LP);
    rc_mode  = (osc_mode_i == rts_pkg::RTS_INRC) || (osc_mode_i == rts_pkg::RTS_EXRC);
    osc_rise = osc_input_pin_i && !r.osc_d;
    access   = psel_i && penable_i && !r.ready;
    hit_power_control_flags = paddr_i == `RTS_POWER_CONTROL_FLAGS_ADDR;
    hit_stat = paddr_i == `RTS_STAT_ADDR;
    next_r          = r;
    next_r.osc_d    = osc_input_pin_i;
    next_r.pc_load  = 1'b0;
    next_r.ready    = access;
    next_r.slverr   = 1'b0;
    // ============================================================
    // Master clear glitch filter; a watchdog event never touches this pin
    if (master_clear_n_i == r.master_clear_n_n)
      next_r.filt = 8'h00;
    else if (r.filt >= 8'(`RTS_MASTER_CLEAR_N_FILT_CYC - 1))
    begin
      next_r.master_clear_n_n = master_clear_n_i;
      next_r.filt   = 8'h00;
    end
    else
      next_r.filt = r.filt + 8'h01;
    // ============================================================
    // Sequencer; delays count regardless of master clear
    case (r.st)
      rts_pkg::RTS_ST_POR:
      begin
        next_r.reset = 1'b1;
        next_r.cnt   = 32'h0;
        if (por_supply_ok_i)
        begin
          if (!power_up_timer_enable_n_i)
            next_r.st = rts_pkg::RTS_ST_POWER_UP_TIMER;
          else if (crystal)
            next_r.st = rts_pkg::RTS_ST_OST;
          else
            next_r.st = rts_pkg::RTS_ST_HOLD;
        end
      end
      rts_pkg::RTS_ST_POWER_UP_TIMER:
      begin
        if (slow_tick_i)
          next_r.cnt = r.cnt + 32'h1;
        if (r.cnt >= 32'(POWER_UP_TIMER_CYCLES))
        begin
          next_r.cnt = 32'h0;
          next_r.st  = crystal ? rts_pkg::RTS_ST_OST : rts_pkg::RTS_ST_HOLD;
        end
      end
      rts_pkg::RTS_ST_OST:
      begin
        if (osc_rise)
          next_r.cnt = r.cnt + 32'h1;
        if (r.cnt >= 32'(OST_CYCLES))
        begin
          next_r.cnt = 32'h0;
          next_r.st  = r.was_sleep && !r.wake_master_clear_n ? rts_pkg::RTS_ST_RUN
                                                   : rts_pkg::RTS_ST_HOLD;
          if (r.was_sleep && !r.wake_master_clear_n)
            next_r.reset = 1'b0;
        end
      end
      rts_pkg::RTS_ST_HOLD:
      begin
        next_r.was_sleep = 1'b0;
        next_r.wake_master_clear_n = 1'b0;
        if (r.master_clear_n_n)
        begin
          next_r.reset   = 1'b0;
          next_r.pc_load = 1'b1;
          next_r.pc_val  = `RTS_PC_RESET;
          next_r.st      = rts_pkg::RTS_ST_RUN;
        end
      end
      rts_pkg::RTS_ST_RUN:
      begin
        if (!r.master_clear_n_n)
        begin
          next_r.reset = 1'b1;
          next_r.st    = rts_pkg::RTS_ST_HOLD;
        end
        else if (wdt_timeout_i)
        begin
          next_r.to_flag = 1'b0;
          next_r.reset   = 1'b1;
          next_r.st      = rts_pkg::RTS_ST_HOLD;
        end
        else if (sleep_req_i)
        begin
          next_r.to_flag = 1'b1;
          next_r.pd_flag = 1'b0;
          next_r.st      = rts_pkg::RTS_ST_SLP;
        end
      end
      rts_pkg::RTS_ST_SLP:
      begin
        next_r.was_sleep = 1'b1;
        if (!r.master_clear_n_n)
        begin
          next_r.to_flag   = 1'b1;
          next_r.pd_flag   = 1'b0;
          next_r.reset     = 1'b1;
          next_r.wake_master_clear_n = 1'b1;
          next_r.st        = crystal ? rts_pkg::RTS_ST_OST : rts_pkg::RTS_ST_HOLD;
        end
        else if (wdt_timeout_i || irq_wake_i)
        begin
          next_r.to_flag = !wdt_timeout_i;
          next_r.pd_flag = 1'b0;
          next_r.pc_load = 1'b1;
          next_r.pc_val  = (irq_wake_i && !wdt_timeout_i && global_irq_enable_i) ?
                           `RTS_PC_IRQ_VEC : 13'(pc_i + 13'h0001);
          if (crystal)
          begin
            next_r.reset = 1'b1;
            next_r.cnt   = 32'h0;
            next_r.st    = rts_pkg::RTS_ST_OST;
          end
          else
            next_r.st = rts_pkg::RTS_ST_RUN;
        end
      end
      default:
        next_r.st = rts_pkg::RTS_ST_POR;
    endcase
    // ============================================================
    // Oscillator pins while reset is held
    next_r.oe1_n = 1'b1;
    next_r.oe2_n = !(next_r.reset && !next_r.master_clear_n_n && rc_mode && clkout_en_i);
    // ============================================================
    // APB slave, one wait state
    if (access)
    begin
      next_r.rdata = 32'h0;
      if (hit_power_control_flags)
      begin
        if (pwrite_i && pwdata_i[`RTS_POWER_CONTROL_FLAGS_POR_BIT])
          next_r.por_flag = 1'b1;
        next_r.rdata = {30'h0, r.por_flag, 1'b0};
      end
      else if (hit_stat)
        next_r.rdata = {27'h0, r.st == rts_pkg::RTS_ST_SLP, r.reset, `RTS_STATUS_HI_POR == 3'h0,
                        r.to_flag, r.pd_flag};
      else if (paddr_i != `RTS_CTRL_ADDR)
        next_r.slverr = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      r          <= '0;
      r.st       <= rts_pkg::RTS_ST_POR;
      r.to_flag  <= 1'b1;
      r.pd_flag  <= 1'b1;
      r.reset    <= 1'b1;
      r.master_clear_n_n   <= 1'b1;
      r.oe1_n    <= 1'b1;
      r.oe2_n    <= 1'b1;
    end
    else
      r <= next_r;
  end

  assign pready_o                = r.ready;
  assign pslverr_o               = r.slverr;
  assign prdata_o                = r.rdata;
  assign chip_reset_o            = r.reset;
  assign pc_load_o               = r.pc_load;
  assign pc_value_o              = r.pc_val;
  assign watchdog_timeout_flag_o = r.to_flag;
  assign power_down_flag_o       = r.pd_flag;
  assign osc_output_pin_o        = 1'b0;
  assign osc_output_pin_oe_n_o   = r.oe2_n;
  assign osc_input_pin_oe_n_o    = r.oe1_n;

  // ============================================================
  // Checks
  a_reset_in_timer: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (r.st == rts_pkg::RTS_ST_POWER_UP_TIMER) |-> chip_reset_o) else $error("reset low in timer");
  a_por_holds: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (r.st == rts_pkg::RTS_ST_POR) |=> chip_reset_o) else $error("reset low before supply");
  a_ost_crystal: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (r.st == rts_pkg::RTS_ST_OST) |-> crystal) else $error("start-up timer in RC mode");
  a_rc_no_delay: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (r.st == rts_pkg::RTS_ST_POR && por_supply_ok_i && rc_mode && power_up_timer_enable_n_i)
    |=> r.st == rts_pkg::RTS_ST_HOLD) else $error("RC mode delayed");
  a_power_control_flags_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (pready_o && !pslverr_o) |-> prdata_o[31:8] == 24'h0) else $error("reserved bits set");
  a_in_pin_tri: assert property (@(posedge clk_i) disable iff (!resetn_i)
    osc_input_pin_oe_n_o) else $error("input pin driven");
  a_hold_release: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (r.st == rts_pkg::RTS_ST_HOLD && r.master_clear_n_n) |=> (!chip_reset_o && pc_load_o &&
    pc_value_o == 13'h0000)) else $error("no immediate start");
  a_irq_vector: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (r.st == rts_pkg::RTS_ST_SLP && r.master_clear_n_n && irq_wake_i && !wdt_timeout_i &&
    global_irq_enable_i) |=> pc_value_o == 13'h0004) else $error("vector wrong");
  a_wdt_flags: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (r.st == rts_pkg::RTS_ST_RUN && r.master_clear_n_n && wdt_timeout_i) |=>
    (!watchdog_timeout_flag_o && power_down_flag_o == $past(r.pd_flag))) else
    $error("watchdog flags wrong");

  // ============================================================
  // Sequencing checks
  a_power_up_timer_entry: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (r.st == rts_pkg::RTS_ST_POWER_UP_TIMER) |->
    ($past(r.st) == rts_pkg::RTS_ST_POWER_UP_TIMER || $past(r.st) == rts_pkg::RTS_ST_POR))
    else $error("power-up timer entered out of order");
  a_ost_entry: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (r.st == rts_pkg::RTS_ST_OST) |->
    ($past(r.st) != rts_pkg::RTS_ST_RUN && $past(r.st) != rts_pkg::RTS_ST_HOLD))
    else $error("start-up timer entered out of order");
  a_power_up_timer_used: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (r.st == rts_pkg::RTS_ST_POR && por_supply_ok_i && !power_up_timer_enable_n_i)
    |=> r.st == rts_pkg::RTS_ST_POWER_UP_TIMER)
    else $error("power-up timer not started");
  a_power_up_timer_skipped: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (r.st == rts_pkg::RTS_ST_POR && por_supply_ok_i && power_up_timer_enable_n_i)
    |=> r.st != rts_pkg::RTS_ST_POWER_UP_TIMER)
    else $error("disabled power-up timer ran");
  a_power_up_timer_bound: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (r.st == rts_pkg::RTS_ST_POWER_UP_TIMER) |->
    r.cnt <= 32'(POWER_UP_TIMER_CYCLES))
    else $error("power-up count overrun");
  a_power_up_timer_exit: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (r.st == rts_pkg::RTS_ST_POWER_UP_TIMER && r.cnt >= 32'(POWER_UP_TIMER_CYCLES)) |=>
    (r.st == rts_pkg::RTS_ST_OST || r.st == rts_pkg::RTS_ST_HOLD))
    else $error("power-up timer did not end");
  a_ost_bound: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (r.st == rts_pkg::RTS_ST_OST) |->
    r.cnt <= 32'(OST_CYCLES))
    else $error("start-up count overrun");
  a_ost_exit: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (r.st == rts_pkg::RTS_ST_OST && r.cnt >= 32'(OST_CYCLES)) |=>
    (r.st == rts_pkg::RTS_ST_RUN || r.st == rts_pkg::RTS_ST_HOLD))
    else $error("start-up timer did not end");
  a_ost_reset: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (r.st == rts_pkg::RTS_ST_OST) |->
    chip_reset_o)
    else $error("reset low in start-up timer");
  a_hold_reset: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (r.st == rts_pkg::RTS_ST_HOLD) |->
    chip_reset_o)
    else $error("reset low while held");
  a_run_released: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (r.st == rts_pkg::RTS_ST_RUN) |->
    !chip_reset_o)
    else $error("reset high while running");
  a_rc_wake: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (r.st == rts_pkg::RTS_ST_SLP && r.master_clear_n_n && (wdt_timeout_i || irq_wake_i) && rc_mode)
    |=> (r.st == rts_pkg::RTS_ST_RUN && !chip_reset_o))
    else $error("RC wake delayed");
  a_xtal_wake: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (r.st == rts_pkg::RTS_ST_SLP && r.master_clear_n_n && (wdt_timeout_i || irq_wake_i) && crystal)
    |=> (r.st == rts_pkg::RTS_ST_OST && chip_reset_o))
    else $error("crystal wake without start-up timer");

  // ============================================================
  // Flag and counter checks
  a_sleep_flags: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (r.st == rts_pkg::RTS_ST_RUN && r.master_clear_n_n && !wdt_timeout_i && sleep_req_i) |=>
    (watchdog_timeout_flag_o && !power_down_flag_o))
    else $error("sleep entry flags wrong");
  a_master_clear_n_run_keep: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (r.st == rts_pkg::RTS_ST_RUN && !r.master_clear_n_n) |=>
    (r.to_flag == $past(r.to_flag) && r.pd_flag == $past(r.pd_flag) && chip_reset_o))
    else $error("master clear in run changed flags");
  a_master_clear_n_sleep: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (r.st == rts_pkg::RTS_ST_SLP && !r.master_clear_n_n) |=>
    (watchdog_timeout_flag_o && !power_down_flag_o && chip_reset_o))
    else $error("master clear in sleep flags wrong");
  a_wdt_wake: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (r.st == rts_pkg::RTS_ST_SLP && r.master_clear_n_n && wdt_timeout_i) |=> (!watchdog_timeout_flag_o
    && !power_down_flag_o && pc_load_o && pc_value_o == $past(pc_i) + 13'h0001))
    else $error("watchdog wake wrong");
  a_irq_wake_flags: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (r.st == rts_pkg::RTS_ST_SLP && r.master_clear_n_n && !wdt_timeout_i && irq_wake_i) |=>
    (watchdog_timeout_flag_o && !power_down_flag_o && pc_load_o))
    else $error("interrupt wake flags wrong");
  a_irq_no_gie: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (r.st == rts_pkg::RTS_ST_SLP && r.master_clear_n_n && !wdt_timeout_i && irq_wake_i &&
    !global_irq_enable_i) |=> pc_value_o == $past(pc_i) + 13'h0001)
    else $error("interrupt wake counter wrong");
  a_por_flag_set: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (access && hit_power_control_flags && pwrite_i && pwdata_i[`RTS_POWER_CONTROL_FLAGS_POR_BIT]) |=>
    r.por_flag)
    else $error("power-on flag not set");
  a_por_flag_keep: assert property (@(posedge clk_i) disable iff (!resetn_i)
    r.por_flag |=>
    r.por_flag)
    else $error("power-on flag lost");

  // ============================================================
  // Bus, filter and pin checks
  a_power_control_flags_unused: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (access && hit_power_control_flags) |=>
    (prdata_o[31:2] == 30'h0 && !prdata_o[0]))
    else $error("unused control bits set");
  a_ready_answer: assert property (@(posedge clk_i) disable iff (!resetn_i)
    access |=>
    pready_o)
    else $error("no ready after access");
  a_bad_addr: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (access && !hit_power_control_flags && !hit_stat && paddr_i != `RTS_CTRL_ADDR) |=>
    pslverr_o)
    else $error("unmapped access accepted");
  a_master_clear_n_filtered: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (r.master_clear_n_n != $past(r.master_clear_n_n)) |->
    $past(r.filt) == 8'(`RTS_MASTER_CLEAR_N_FILT_CYC - 1))
    else $error("short master clear pulse passed");
  a_clkout_drive: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !osc_output_pin_oe_n_o |->
    (chip_reset_o && !r.master_clear_n_n && !osc_output_pin_o))
    else $error("output pin driven outside reset");
  a_io_tristate: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !clkout_en_i |=>
    osc_output_pin_oe_n_o)
    else $error("output pin driven in I/O mode");
  c_xtal_wake: cover property (@(posedge clk_i) r.st == rts_pkg::RTS_ST_SLP ##1
    r.st == rts_pkg::RTS_ST_OST);
  c_power_up_timer_run: cover property (@(posedge clk_i) r.st == rts_pkg::RTS_ST_POWER_UP_TIMER);
  c_ost_run: cover property (@(posedge clk_i) r.st == rts_pkg::RTS_ST_OST);
  c_sleep_wake: cover property (@(posedge clk_i) r.st == rts_pkg::RTS_ST_SLP ##1
    r.st == rts_pkg::RTS_ST_RUN);
endmodule

// ---- dv/rts_ext_model.sv ----
// Far-side model: free-running crystal on the input pin and the slow timer tick
`timescale 1ns/10ps
module rts_ext_model (
  input  wire logic clk_i,
  output logic      osc_input_pin_o,
  output logic      slow_tick_o
);
  int cnt;
  initial
  begin
    cnt = 0;
    osc_input_pin_o = 1'b0;
    slow_tick_o = 1'b0;
  end
  // ==========================================================
  // Pin period 6 clocks, tick every 4: unrelated rates on purpose
  always @(posedge clk_i)
  begin
    cnt <= cnt + 1;
    slow_tick_o <= (cnt % 4 == 3);
    if (cnt % 3 == 0)
      osc_input_pin_o <= !osc_input_pin_o;
  end
endmodule

// ---- dv/reset_timeout_sequencer_tb_top.sv ----
// Self-checking bench for the reset sequencer
`timescale 1ns/10ps
module reset_timeout_sequencer_tb_top;
  logic        clk_i, resetn_i, supply, tick, osc, clkout, en_n, master_clear_n_n;
  logic        wdt, slp, irq, global_irq_enable, psel, penable, pwrite, pready, err;
  logic        creset, pc_load, to_f, pd_f, opin, opin_oe_n, ipin_oe_n;
  logic [2:0]  mode;
  logic [12:0] pc, pc_val;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          miscompares, num_checks, cyc, t0;
  rts_ext_model u_ext (.clk_i(clk_i), .osc_input_pin_o(osc), .slow_tick_o(tick));
  // Short counts keep the run small
  rts_reset_seq #(.POWER_UP_TIMER_CYCLES(8), .OST_CYCLES(4)) u_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .por_supply_ok_i(supply),
    .slow_tick_i(tick), .osc_input_pin_i(osc), .osc_mode_i(mode),
    .clkout_en_i(clkout), .power_up_timer_enable_n_i(en_n),
    .master_clear_n_i(master_clear_n_n), .wdt_timeout_i(wdt), .sleep_req_i(slp),
    .irq_wake_i(irq), .global_irq_enable_i(global_irq_enable), .pc_i(pc),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pready_o(pready), .pslverr_o(err), .prdata_o(prdata),
    .chip_reset_o(creset), .pc_load_o(pc_load), .pc_value_o(pc_val),
    .watchdog_timeout_flag_o(to_f), .power_down_flag_o(pd_f),
    .osc_output_pin_o(opin), .osc_output_pin_oe_n_o(opin_oe_n),
    .osc_input_pin_oe_n_o(ipin_oe_n));
  // ==========================================================
  // Tasks
  task conclude();
    if (miscompares == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask
  // Samples in the edge's active region, so pre-edge values are seen
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clk_i);
    end
    if (n == 50)
      miscompares++;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_pc(input logic [12:0] e);
    int n;
    n = 0;
    @(posedge clk_i);
    while (pc_load !== 1'b1 && n < 2000)
    begin
      n++;
      @(posedge clk_i);
    end
    if (n == 2000)
      miscompares++;
    chk(pc_val, e);
  endtask
  task pulse(input int k);
    if (k == 0) wdt <= 1'b1;
    if (k == 1) slp <= 1'b1;
    if (k == 2) irq <= 1'b1;
    @(posedge clk_i);
    {wdt, slp, irq} <= 3'h0;
    repeat (4) @(posedge clk_i);
  endtask
  task por(input logic [2:0] m, input logic e, input logic h, input int lo, input int hi);
    resetn_i <= 1'b0;
    supply <= 1'b0;
    mode <= m;
    en_n <= e;
    master_clear_n_n <= !h;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk(creset, 1);
    supply <= 1'b1;
    if (h)
    begin
      repeat (300) @(posedge clk_i);
      master_clear_n_n <= 1'b1;
    end
    t0 = cyc;
    wait_pc(13'h0);
    chk(cyc - t0 >= lo && cyc - t0 <= hi, 1);
  endtask
  // ==========================================================
  // Clock, timeout, tests
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      conclude();
    end
  end
  initial
  begin
    {resetn_i, supply, clkout, en_n, wdt, slp, irq, global_irq_enable} = '0;
    {psel, penable, pwrite, paddr, pwdata, mode} = '0;
    master_clear_n_n = 1'b1;
    pc = 13'h0123;
    repeat (2) @(posedge clk_i);
    por(3'h0, 0, 0, 45, 300);
    chk({to_f, pd_f}, 2'b11);
    apb(0, 12'h004, 0);
    chk(rd & 32'h1b, 32'h3);
    apb(0, 12'h238, 0);
    chk(rd, 0);
    apb(1, 12'h238, 32'hffffffff);
    apb(0, 12'h238, 0);
    chk(rd, 32'h2);
    apb(0, 12'h100, 0);
    chk(err, 1);
    pulse(0);
    chk({to_f, pd_f}, 2'b01);
    apb(0, 12'h238, 0);
    chk(rd, 32'h2);
    master_clear_n_n <= 1'b0;
    repeat (2) @(posedge clk_i);
    master_clear_n_n <= 1'b1;
    // A two-cycle glitch must not reach the chip
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk_i);
      chk(creset, 0);
    end
    mode <= 3'h4;
    clkout <= 1'b1;
    master_clear_n_n <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk({opin, opin_oe_n, ipin_oe_n}, 3'b001);
    clkout <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(opin_oe_n, 1);
    master_clear_n_n <= 1'b1;
    wait_pc(13'h0);
    chk({to_f, pd_f}, 2'b01);
    pulse(1);
    chk({to_f, pd_f}, 2'b10);
    global_irq_enable <= 1'b1;
    pulse(2);
    chk(pc_val, 13'h4);
    chk({to_f, pd_f}, 2'b10);
    pulse(1);
    pulse(0);
    chk(pc_val, 13'h124);
    chk({to_f, pd_f}, 2'h0);
    por(3'h4, 1, 0, 0, 12);
    por(3'h0, 0, 1, 0, 12);
    chk({to_f, pd_f}, 2'b11);
    // Crystal wake must rerun the start-up timer before release
    pulse(1);
    pulse(2);
    chk(creset, 1);
    chk(pc_val, 13'h4);
    repeat (40) @(posedge clk_i);
    chk(creset, 0);
    chk({to_f, pd_f}, 2'h2);
    conclude();
  end
endmodule
